// file: rtl/gsled_top.sv
// gateway status led encoder: six front-panel leds driven from status
// conditions written by software and from port link/activity inputs.
// assumes one 50 MHz clock, inputs synchronous to it, AHB-Lite master.
module gsled_top #(
  parameter int unsigned TICK_CYCLES = gsled_pkg::TICK_CYCLES,
  parameter int unsigned FLASH_TICKS = gsled_pkg::FLASH_TICKS,
  parameter int unsigned FLICKER_TICKS = gsled_pkg::FLICKER_TICKS
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire gsled_pkg::gsled_port_t port1,
  input wire gsled_pkg::gsled_port_t port2,
  output gsled_pkg::gsled_colour_t led_net,
  output gsled_pkg::gsled_colour_t led_module,
  output gsled_pkg::gsled_colour_t led_port1,
  output gsled_pkg::gsled_colour_t led_port2,
  output gsled_pkg::gsled_colour_t led_can,
  output gsled_pkg::gsled_colour_t led_device,
  output logic run_mode,
  output logic irq
);

  // refuse settings that the 24-bit and 8-bit counters cannot hold
  if (TICK_CYCLES < 2 || TICK_CYCLES > 32'h00ff_ffff)
  begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end
  if (FLASH_TICKS < 2 || FLASH_TICKS > 255 || FLICKER_TICKS < 1 || FLICKER_TICKS > 255)
  begin : g_bad_ticks
    $error("pattern tick counts out of range");
  end

  // ***********************************************************************
  // shared timebase
  // ***********************************************************************
  logic [23:0] pre_cnt, next_pre_cnt;
  logic [7:0] slot_cnt, next_slot_cnt;
  logic [7:0] flk_cnt, next_flk_cnt;
  logic [3:0] seq_cnt, next_seq_cnt;
  logic flk_ph, next_flk_ph;
  logic tick;
  gsled_pkg::gsled_phase_t ph;

  // one prescaler feeds every pattern so all leds blink in step
  always_comb
  begin
    tick = (pre_cnt == 24'(TICK_CYCLES - 1));
    next_pre_cnt = tick ? 24'h000000 : pre_cnt + 24'h000001;
    next_slot_cnt = slot_cnt;
    next_seq_cnt = seq_cnt;
    next_flk_cnt = flk_cnt;
    next_flk_ph = flk_ph;
    if (tick)
    begin
      if (slot_cnt == 8'(FLASH_TICKS - 1))
      begin
        next_slot_cnt = 8'h00;
        next_seq_cnt = (seq_cnt == 4'hb) ? 4'h0 : seq_cnt + 4'h1;
      end
      else
        next_slot_cnt = slot_cnt + 8'h01;
      if (flk_cnt == 8'(FLICKER_TICKS - 1))
      begin
        next_flk_cnt = 8'h00;
        next_flk_ph = ~flk_ph;
      end
      else
        next_flk_cnt = flk_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pre_cnt <= 24'h000000;
      slot_cnt <= 8'h00;
      seq_cnt <= 4'h0;
      flk_cnt <= 8'h00;
      flk_ph <= 1'b0;
    end
    else if (clk_en)
    begin
      pre_cnt <= next_pre_cnt;
      slot_cnt <= next_slot_cnt;
      seq_cnt <= next_seq_cnt;
      flk_cnt <= next_flk_cnt;
      flk_ph <= next_flk_ph;
    end
  end

  // 12-slot frame: n pulses on even slots, then a dark gap
  function automatic logic group_on(input logic [3:0] seq, input logic [3:0] n);
    group_on = !seq[0] && (seq < {n[2:0], 1'b0});
  endfunction

  always_comb
  begin
    ph.flash = seq_cnt[0];
    ph.flicker = flk_ph;
    ph.single = group_on(seq_cnt, 4'h1);
    ph.dbl = group_on(seq_cnt, 4'h2);
    ph.triple = group_on(seq_cnt, 4'h3);
    ph.quad = group_on(seq_cnt, 4'h4);
  end

  // ***********************************************************************
  // ahb-lite slave
  // ***********************************************************************
  logic [31:0] cond, next_cond;
  logic [3:0] irq_status, next_irq_status;
  logic [3:0] irq_mask, next_irq_mask;
  logic [7:0] wr_addr, next_wr_addr;
  logic wr_pend, next_wr_pend;
  logic [31:0] next_hrdata;
  logic [3:0] irq_event;
  logic addr_phase;

  function automatic logic [31:0] led_word(input gsled_pkg::gsled_colour_t a,
                                           input gsled_pkg::gsled_colour_t b,
                                           input gsled_pkg::gsled_colour_t c,
                                           input gsled_pkg::gsled_colour_t d,
                                           input gsled_pkg::gsled_colour_t e,
                                           input gsled_pkg::gsled_colour_t f);
    led_word = {20'h00000, f, e, d, c, b, a};
  endfunction

  // zero wait states; a write lands in its data phase
  always_comb
  begin
    addr_phase = hsel && hready && htrans[1];
    next_wr_pend = addr_phase && hwrite;
    next_wr_addr = addr_phase ? haddr[7:0] : wr_addr;
    next_hrdata = hrdata;
    if (addr_phase && !hwrite)
    begin
      case (haddr[7:0])
        gsled_pkg::ADDR_COND: next_hrdata = cond;
        gsled_pkg::ADDR_LEDS: next_hrdata = led_word(led_net, led_module, led_port1,
                                                     led_port2, led_can, led_device);
        gsled_pkg::ADDR_IRQ_STATUS: next_hrdata = {28'h0000000, irq_status};
        gsled_pkg::ADDR_IRQ_MASK: next_hrdata = {28'h0000000, irq_mask};
        gsled_pkg::ADDR_ID: next_hrdata = gsled_pkg::ID_VALUE; // arbitrary id value
        default: next_hrdata = 32'h00000000; // unmapped reads zero
      endcase
    end
    next_cond = cond;
    next_irq_mask = irq_mask;
    // hardware set wins over a simultaneous write-one clear
    next_irq_status = irq_status | irq_event;
    if (wr_pend)
    begin
      case (wr_addr)
        gsled_pkg::ADDR_COND: next_cond = hwdata;
        gsled_pkg::ADDR_IRQ_STATUS: next_irq_status = (irq_status & ~hwdata[3:0]) | irq_event;
        gsled_pkg::ADDR_IRQ_MASK: next_irq_mask = hwdata[3:0];
        default: next_cond = cond;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cond <= gsled_pkg::COND_RESET;
      irq_status <= 4'h0;
      irq_mask <= gsled_pkg::IRQ_MASK_RESET;
      wr_addr <= 8'h00;
      wr_pend <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      cond <= next_cond;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      wr_addr <= next_wr_addr;
      wr_pend <= next_wr_pend;
      hrdata <= next_hrdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(irq_status & irq_mask);

  // ***********************************************************************
  // led encoding
  // ***********************************************************************
  gsled_pkg::gsled_colour_t next_net, next_module, next_p1, next_p2, next_can, next_dev;
  logic fault_any, can_err, link_q, online_q;
  logic next_fault_any, next_can_err;

  function automatic gsled_pkg::gsled_colour_t port_led(input gsled_pkg::gsled_port_t p,
                                                        input logic flick);
    if (!p.link)
      port_led = gsled_pkg::GSLED_OFF;
    else if (p.activity && flick)
      port_led = gsled_pkg::GSLED_OFF;
    else
      port_led = gsled_pkg::GSLED_GREEN;
  endfunction

  function automatic gsled_pkg::gsled_colour_t on_if(input logic on,
                                                     input gsled_pkg::gsled_colour_t c);
    on_if = on ? c : gsled_pkg::GSLED_OFF;
  endfunction

  always_comb
  begin
    // network communication
    if (!cond[gsled_pkg::B_NET_ONLINE])
      next_net = gsled_pkg::GSLED_OFF;
    else if (cond[gsled_pkg::B_CTRL_RUN])
      next_net = gsled_pkg::GSLED_GREEN;
    else
      next_net = on_if(ph.single, gsled_pkg::GSLED_GREEN);
    // module status: faults first, then identify, then health
    if (cond[gsled_pkg::B_INT_ERR])
      next_module = on_if(ph.quad, gsled_pkg::GSLED_RED);
    else if (cond[gsled_pkg::B_NO_NAME])
      next_module = on_if(ph.triple, gsled_pkg::GSLED_RED);
    else if (cond[gsled_pkg::B_CFG_ERR])
      next_module = on_if(ph.single, gsled_pkg::GSLED_RED);
    else if (cond[gsled_pkg::B_IDENT])
      next_module = on_if(ph.dbl, gsled_pkg::GSLED_GREEN);
    else if (!cond[gsled_pkg::B_INIT])
      next_module = gsled_pkg::GSLED_OFF;
    else if (cond[gsled_pkg::B_DIAG])
      next_module = on_if(ph.single, gsled_pkg::GSLED_GREEN);
    else
      next_module = gsled_pkg::GSLED_GREEN;
    next_p1 = port_led(port1, ph.flicker);
    next_p2 = port_led(port2, ph.flicker);
    // can subnetwork
    if (cond[gsled_pkg::B_CAN_FATAL])
      next_can = gsled_pkg::GSLED_RED;
    else if (cond[gsled_pkg::B_CAN_TRERR] || cond[gsled_pkg::B_CAN_STOP])
      next_can = on_if(ph.flash, gsled_pkg::GSLED_RED);
    else if (!cond[gsled_pkg::B_CAN_ACTIVE])
      next_can = gsled_pkg::GSLED_OFF;
    else if (!cond[gsled_pkg::B_CAN_ALL_DONE])
      next_can = on_if(ph.flash, gsled_pkg::GSLED_GREEN);
    else
      next_can = gsled_pkg::GSLED_GREEN;
    // device status: fatal wins over configuration and mode
    if (cond[gsled_pkg::B_DEV_FATAL])
      next_dev = gsled_pkg::GSLED_RED;
    else if (cond[gsled_pkg::B_CFG_BAD])
      next_dev = ph.flash ? gsled_pkg::GSLED_RED : gsled_pkg::GSLED_GREEN;
    else if (cond[gsled_pkg::B_RUN_MODE])
      next_dev = gsled_pkg::GSLED_GREEN;
    else
      next_dev = on_if(ph.flash, gsled_pkg::GSLED_GREEN);
    // event sources for the interrupt status
    next_fault_any = cond[gsled_pkg::B_INT_ERR] | cond[gsled_pkg::B_NO_NAME] |
                     cond[gsled_pkg::B_CFG_ERR] | cond[gsled_pkg::B_DEV_FATAL];
    next_can_err = cond[gsled_pkg::B_CAN_TRERR] | cond[gsled_pkg::B_CAN_FATAL];
    irq_event[gsled_pkg::IRQ_FAULT] = next_fault_any & ~fault_any;
    irq_event[gsled_pkg::IRQ_CAN_ERR] = next_can_err & ~can_err;
    irq_event[gsled_pkg::IRQ_LINK_CHG] = (port1.link ^ port2.link) != link_q;
    irq_event[gsled_pkg::IRQ_ONLINE_CHG] = cond[gsled_pkg::B_NET_ONLINE] != online_q;
  end

  // registered led drive keeps the pins glitch free
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      led_net <= gsled_pkg::GSLED_OFF;
      led_module <= gsled_pkg::GSLED_OFF;
      led_port1 <= gsled_pkg::GSLED_OFF;
      led_port2 <= gsled_pkg::GSLED_OFF;
      led_can <= gsled_pkg::GSLED_OFF;
      led_device <= gsled_pkg::GSLED_OFF;
      run_mode <= 1'b0;
      fault_any <= 1'b0;
      can_err <= 1'b0;
      link_q <= 1'b0;
      online_q <= 1'b0;
    end
    else if (clk_en)
    begin
      led_net <= next_net;
      led_module <= next_module;
      led_port1 <= next_p1;
      led_port2 <= next_p2;
      led_can <= next_can;
      led_device <= next_dev;
      run_mode <= cond[gsled_pkg::B_RUN_MODE] & ~cond[gsled_pkg::B_DEV_FATAL];
      fault_any <= next_fault_any;
      can_err <= next_can_err;
      link_q <= port1.link ^ port2.link;
      online_q <= cond[gsled_pkg::B_NET_ONLINE];
    end
  end

endmodule

// file: rtl/gsled_pkg.sv
// package for the gateway status led encoder: register map, field layout,
// reset values, pattern timing and led colour types.
// assumes a 50 MHz system clock and an AHB-Lite slave with 32-bit data.
package gsled_pkg;

  // ***********************************************************************
  // timing
  // ***********************************************************************
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned TICK_US = 10000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  localparam int unsigned FLASH_TICKS = 20;
  localparam int unsigned FLICKER_TICKS = 5;

  // ***********************************************************************
  // register map
  // ***********************************************************************
  localparam logic [7:0] ADDR_COND = 8'h00;
  localparam logic [7:0] ADDR_LEDS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_ID = 8'h10;
  localparam logic [31:0] ID_VALUE = 32'h0000_5a01; // arbitrary value, names no maker
  localparam logic [31:0] COND_RESET = 32'h0000_0000;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // condition register fields
  localparam int unsigned B_NET_ONLINE = 0;
  localparam int unsigned B_CTRL_RUN = 1;
  localparam int unsigned B_INIT = 2;
  localparam int unsigned B_DIAG = 3;
  localparam int unsigned B_IDENT = 4;
  localparam int unsigned B_CFG_ERR = 5;
  localparam int unsigned B_NO_NAME = 6;
  localparam int unsigned B_INT_ERR = 7;
  localparam int unsigned B_CAN_ACTIVE = 8;
  localparam int unsigned B_CAN_ALL_DONE = 9;
  localparam int unsigned B_CAN_TRERR = 10;
  localparam int unsigned B_CAN_STOP = 11;
  localparam int unsigned B_CAN_FATAL = 12;
  localparam int unsigned B_CFG_BAD = 13;
  localparam int unsigned B_RUN_MODE = 14;
  localparam int unsigned B_DEV_FATAL = 15;

  // interrupt status bits
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_CAN_ERR = 1;
  localparam int unsigned IRQ_LINK_CHG = 2;
  localparam int unsigned IRQ_ONLINE_CHG = 3;

  typedef enum logic [1:0] {
    GSLED_OFF = 2'b00,
    GSLED_GREEN = 2'b01,
    GSLED_RED = 2'b10
  } gsled_colour_t;

  // pattern phases shared by every led
  typedef struct packed {
    logic flash;
    logic flicker;
    logic single;
    logic dbl;
    logic triple;
    logic quad;
  } gsled_phase_t;

  typedef struct packed {
    logic link;
    logic activity;
  } gsled_port_t;

endpackage

// file: bench/gsled_top_asserts.sv
// checker for the status led encoder: shadows the condition word from
// bus writes and ties steady led states to it.
// assumes one slave (hready is hreadyout), condition word at 8'h00.
module gsled_top_asserts (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  input wire gsled_pkg::gsled_port_t port1,
  input wire gsled_pkg::gsled_colour_t led_net,
  input wire gsled_pkg::gsled_colour_t led_module,
  input wire gsled_pkg::gsled_colour_t led_port1,
  input wire gsled_pkg::gsled_colour_t led_can,
  input wire gsled_pkg::gsled_colour_t led_device
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_p;
  logic quiet;
  logic [15:0] cond;
  // *****
  // shadow state
  // *****
  // quiet: leds had one enabled edge since the last store, so they are current
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      {wr_p, quiet, cond} <= 18'h0;
    else
    begin
      quiet <= clk_en && !wr_p;
      wr_p <= clk_en ? (hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00) : wr_p;
      cond <= (clk_en && wr_p) ? hwdata[15:0] : cond;
    end
  end
  // *****
  // led relations, 00 off 01 green 10 red
  // *****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  chk_net_dark: assert property (quiet && !cond[0] |-> led_net == 2'h0)
    else $error("net led lit offline");
  chk_net_run: assert property (quiet && cond[1:0] == 2'h3 |-> led_net == 2'h1)
    else $error("net led not green in run");
  chk_mod_ok: assert property (quiet && cond[7:2] == 6'h01 |-> led_module == 2'h1)
    else $error("module led not green");
  chk_mod_fault: assert property (quiet && cond[7:5] != 3'h0 |-> led_module != 2'h1)
    else $error("module led green on fault");
  chk_mod_ident: assert property (quiet && cond[7:4] == 4'h1 |-> led_module != 2'h2)
    else $error("module led red on identify");
  chk_can_dark: assert property (quiet && cond[12:10] == 3'h0 && !cond[8] |-> led_can == 2'h0)
    else $error("can led lit without traffic");
  chk_can_fatal: assert property (quiet && cond[12] |-> led_can == 2'h2)
    else $error("can led not red on fatal");
  chk_dev_fatal: assert property (quiet && cond[15] |-> led_device == 2'h2)
    else $error("device led not red on fatal");
  chk_dev_alt: assert property (quiet && !cond[15] && cond[13] |-> led_device != 2'h0)
    else $error("device led dark while alternating");
  chk_port_dark: assert property (quiet && !port1.link && !$past(port1.link) |-> led_port1 == 2'h0)
    else $error("port led lit without link");
  chk_port_green: assert property (port1 == 2'b10 [*2] ##0 quiet |-> led_port1 == 2'h1)
    else $error("port led not green on idle link");
  cover property (quiet && cond[7:5] == 3'h3);
  cover property (quiet && !cond[15] && cond[13]);
  cover property (port1 == 2'b11 && led_port1 == 2'h0);
endmodule
bind gsled_top gsled_top_asserts u_gsled_top_asserts (.ref_clk(ref_clk), .arst_n(arst_n),
  .clk_en(clk_en), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hsel(hsel),
  .hready(hready), .port1(port1), .led_net(led_net), .led_module(led_module),
  .led_port1(led_port1), .led_can(led_can), .led_device(led_device));

// file: bench/gsled_panel.sv
// panel model: an observer counting, over one whole frame, how many
// cycles the chosen led glows green and how many red.
// assumes go is a one-cycle request made just after a rising edge.
module gsled_panel #(
  parameter int FRAME = 96
) (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [2:0] sel,
  input wire logic [11:0] leds,
  output logic done,
  output logic [7:0] g_cnt,
  output logic [7:0] r_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left = 8'h0;
  logic [1:0] lamp;
  // *****
  // counting
  // *****
  // a whole frame makes the count blind to where the pattern starts
  assign lamp = leds[2 * sel +: 2];
  always @(posedge ref_clk)
  begin
    done <= left == 8'h1;
    left <= go ? 8'(FRAME) : left - 8'(left != 8'h0);
    g_cnt <= go ? 8'h0 : g_cnt + 8'(left != 8'h0 && lamp == 2'h1);
    r_cnt <= go ? 8'h0 : r_cnt + 8'(left != 8'h0 && lamp == 2'h2);
  end
endmodule

// file: bench/test_gateway_status_led_encoder.sv
// testbench for the status led encoder: bus master, port stimulus and
// frame-long led counts from the panel model, checked from a queue.
// assumes a short timebase: 8-cycle slots, 96-cycle pattern frame.
module test_gateway_status_led_encoder;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLOT = 8;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hwrite = 1'b0;
  logic go = 1'b0;
  logic rd_dp = 1'b0;
  logic hsel = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] sel = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  gsled_pkg::gsled_port_t port1 = 2'h0;
  gsled_pkg::gsled_port_t port2 = 2'h0;
  logic [31:0] hrdata;
  logic hreadyout, irq, done, hresp, run_mode;
  logic [7:0] g_cnt, r_cnt;
  gsled_pkg::gsled_colour_t l_net, l_mod, l_p1, l_p2, l_can, l_dev;
  logic [31:0] q[$];
  int n_errors = 0;
  int n_checks = 0;
  int seed = 7653;
  // *****
  // design and panel
  // *****
  gsled_top #(.TICK_CYCLES(4), .FLASH_TICKS(2), .FLICKER_TICKS(1)) u_gsled_top (.ref_clk(ref_clk),
    .arst_n(arst_n), .clk_en(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .port1(port1), .port2(port2), .led_net(l_net), .led_module(l_mod), .led_port1(l_p1),
    .led_port2(l_p2), .led_can(l_can), .led_device(l_dev), .run_mode(run_mode), .irq(irq));
  gsled_panel #(.FRAME(12 * SLOT)) u_gsled_panel (.ref_clk(ref_clk), .go(go), .sel(sel),
    .leds({l_dev, l_can, l_p2, l_p1, l_mod, l_net}), .done(done), .g_cnt(g_cnt), .r_cnt(r_cnt));
  always #10 ref_clk = ~ref_clk;
  // *****
  // tasks
  // *****
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // one single transfer; a read leaves its expected word in the queue
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    if (!w)
      q.push_back(d);
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  // one frame of one led, expected counts given in slots
  task automatic meas(input logic [2:0] s, input int g, input int r);
    sel <= s;
    go <= 1'b1;
    q.push_back({16'h0, 8'(g * SLOT), 8'(r * SLOT)});
    @(posedge ref_clk);
    go <= 1'b0;
    do @(posedge ref_clk); while (done !== 1'b1);
  endtask
  task automatic pat(input logic [15:0] c, input logic [2:0] s, input int g, input int r);
    bus(8'h00, 1'b1, {16'h0, c});
    repeat (2) @(posedge ref_clk);
    meas(s, g, r);
  endtask
  // irq is combinational, so look at it mid-cycle
  task automatic irq_is(input logic v);
    @(negedge ref_clk);
    check({31'h0, irq}, {31'h0, v});
    @(posedge ref_clk);
  endtask
  function automatic int slots(input gsled_pkg::gsled_port_t p);
    return p.link ? (p.activity ? 6 : 12) : 0;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // *****
  // watcher, watchdog, sequence
  // *****
  // each result takes the oldest note when it shows up
  always @(posedge ref_clk)
  begin
    if (rd_dp === 1'b1)
    begin
      check(hrdata, q.pop_front());
      check({31'h0, hresp}, 32'h0); // slave always answers okay
    end
    if (done === 1'b1)
      check({16'h0, g_cnt, r_cnt}, q.pop_front());
  end
  // about five times the expected run
  initial
  begin
    #(20 * 20000);
    n_errors++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    bus(8'h10, 1'b0, gsled_pkg::ID_VALUE);
    bus(8'h00, 1'b0, gsled_pkg::COND_RESET);
    bus(8'h20, 1'b1, 32'hffff_ffff);
    bus(8'h20, 1'b0, 32'h0);
    $display("test registers done");
    pat(16'h0000, 3'h0, 0, 0);
    pat(16'h0001, 3'h0, 1, 0);
    pat(16'h0003, 3'h0, 12, 0);
    pat(16'h0004, 3'h1, 12, 0);
    pat(16'h000c, 3'h1, 1, 0);
    pat(16'h0014, 3'h1, 2, 0);
    pat(16'h0024, 3'h1, 0, 1);
    pat(16'h0064, 3'h1, 0, 3);
    pat(16'h00e4, 3'h1, 0, 4);
    pat(16'h0100, 3'h4, 6, 0);
    pat(16'h0300, 3'h4, 12, 0);
    pat(16'h0500, 3'h4, 0, 6);
    pat(16'h0900, 3'h4, 0, 6);
    pat(16'h1300, 3'h4, 0, 12);
    pat(16'h0200, 3'h4, 0, 0);
    pat(16'h0000, 3'h5, 6, 0);
    check({31'h0, run_mode}, 32'h0);
    pat(16'h4000, 3'h5, 12, 0);
    check({31'h0, run_mode}, 32'h1);
    pat(16'he000, 3'h5, 0, 12);
    check({31'h0, run_mode}, 32'h0);
    pat(16'h6000, 3'h5, 6, 6);
    $display("test patterns done");
    for (int i = 0; i < 8; i++)
    begin
      port1 <= 2'(i);
      port2 <= 2'($random(seed));
      repeat (3) @(posedge ref_clk);
      meas(3'h2, slots(port1), 0);
      meas(3'h3, slots(port2), 0);
    end
    $display("test ports done");
    bus(8'h08, 1'b1, 32'hf);
    bus(8'h0c, 1'b1, 32'h1);
    bus(8'h08, 1'b0, 32'h0);
    irq_is(1'b0);
    bus(8'h00, 1'b1, 32'h80);
    bus(8'h00, 1'b0, 32'h80);
    bus(8'h08, 1'b0, 32'h1);
    irq_is(1'b1);
    bus(8'h0c, 1'b1, 32'h0);
    irq_is(1'b0);
    bus(8'h0c, 1'b1, 32'h1);
    irq_is(1'b1);
    bus(8'h08, 1'b1, 32'h1);
    irq_is(1'b0);
    bus(8'h08, 1'b0, 32'h0);
    bus(8'h0c, 1'b0, 32'h1);
    $display("test interrupt done");
    conclude();
  end
endmodule
